// ---- logic/tbt_pkg.sv ----
/*
  shared constants and types of the two-channel interval timer:
  mode and source encodings, prescaler counts and reset values.
  assumes nothing beyond a synthesis tool that reads packages.
*/
package tbt_pkg;

  // operating mode, two lowest bits of each channel mode field
  typedef enum logic [1:0] {
    MODE_TIMER   = 2'h0,
    MODE_EVENT   = 2'h1,
    MODE_MEASURE = 2'h2,
    MODE_UNUSED  = 2'h3
  } tbt_mode_e;

  // count-source select field
  localparam logic [1:0] SRC_DIV1  = 2'h0;
  localparam logic [1:0] SRC_DIV8  = 2'h1;
  localparam logic [1:0] SRC_DIV32 = 2'h2;
  localparam logic [1:0] SRC_SUB32 = 2'h3;

  // effective edge select for event counting and measurement
  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h2;

  // prescaler ratios
  localparam int DIV8_COUNT  = 8;
  localparam int DIV32_COUNT = 32;
  localparam int SUB_COUNT   = 32;

  // counter geometry and reset values
  localparam int          CNT_W       = 16;
  localparam logic [15:0] CNT_RST     = 16'h0000;
  localparam logic [15:0] RELOAD_RST  = 16'h0000;
  localparam logic [15:0] CNT_ALL_ONE = 16'hffff;

endpackage : tbt_pkg

// ---- logic/tbt_tick_if.sv ----
/*
  carrier for the shared count-source ticks, prescaler to channels.
  assumes every tick is a one-cycle pulse on the common clock.
*/
`timescale 1ns/10ps
interface tbt_tick_if;
  logic tick_div1;
  logic tick_div8;
  logic tick_div32;
  logic tick_sub32;

  modport src (output tick_div1, tick_div8, tick_div32, tick_sub32);
  modport snk (input  tick_div1, tick_div8, tick_div32, tick_sub32);
endinterface : tbt_tick_if

// ---- logic/tbt_prescaler.sv ----
/*
  prescaler shared by both channels: undivided, divide-by-8 and
  divide-by-32 ticks of the main clock, and divide-by-32 of the
  sub-clock. assumes the sub-clock pin is asynchronous and much slower
  than the main clock, so it is sampled as a level.
*/
`timescale 1ns/10ps
module tbt_prescaler (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_arst_n,
  // sub-clock pin
  input  wire logic i_subclk,
  // tick outputs
  tbt_tick_if.src   tick
);

  logic [2:0] div8_cnt;
  logic [4:0] div32_cnt;
  logic [4:0] sub_cnt;
  logic       sub_meta;
  logic       sub_sync;
  logic       sub_last;

  // main clock dividers
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      div8_cnt  <= 3'h0;
      div32_cnt <= 5'h0;
    end else begin
      div8_cnt  <= div8_cnt + 3'h1;
      div32_cnt <= div32_cnt + 5'h1;
    end
  end

  // two-flop sampling of the sub-clock, then edge memory
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sub_meta <= 1'b0;
      sub_sync <= 1'b0;
      sub_last <= 1'b0;
    end else begin
      sub_meta <= i_subclk;
      sub_sync <= sub_meta;
      sub_last <= sub_sync;
    end
  end

  // sub-clock divider counts rising edges
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sub_cnt <= 5'h0;
    end else if (sub_sync && !sub_last) begin
      sub_cnt <= sub_cnt + 5'h1;
    end
  end

  // registered one-cycle ticks
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tick.tick_div1  <= 1'b0;
      tick.tick_div8  <= 1'b0;
      tick.tick_div32 <= 1'b0;
      tick.tick_sub32 <= 1'b0;
    end else begin
      tick.tick_div1  <= 1'b1;
      tick.tick_div8  <= (div8_cnt == 3'(tbt_pkg::DIV8_COUNT - 1));
      tick.tick_div32 <= (div32_cnt == 5'(tbt_pkg::DIV32_COUNT - 1));
      tick.tick_sub32 <= sub_sync && !sub_last &&
                         (sub_cnt == 5'(tbt_pkg::SUB_COUNT - 1));
    end
  end

endmodule : tbt_prescaler

// ---- logic/tbt_timer.sv ----
/*
  two-channel down-counting interval timer with event counting and
  pulse period / width measurement. each channel has a 16-bit counter,
  a 16-bit reload register and a software timer-register port.
  assumes software ports are synchronous to i_clk; external inputs and
  the sub-clock are asynchronous pins.
*/
// Functional notes
// R1: two channels; mode comes from the two lowest bits of each mode field.
// R2: modes are interval, event counting, and period or width measurement.
// R3: interval source is undivided, divide by 8, 32, or sub-clock by 32.
// R4: count down per tick; on underflow reload and keep counting.
// R5: reload value n gives one underflow every n+1 ticks.
// R6: setting the start flag begins counting.
// R7: clearing the start flag halts counting and holds the value.
// R8: each underflow in interval mode raises the interrupt request.
// R9: reading the timer register in interval mode gives the live count.
// R10: write while stopped loads reload register and counter together.
// R11: write while counting loads reload only; counter takes it at underflow.
// R12: each channel has independent 16-bit counter and reload register.
// R13: two-bit source select field picks one of four internal sources.
`timescale 1ns/10ps
module tbt_timer #(
  parameter int NCH = 2
) (
  // clock and reset
  input  wire logic                  i_clk,
  input  wire logic                  i_arst_n,
  // sub-clock pin
  input  wire logic                  i_subclk,
  // per channel mode field
  input  wire logic [NCH-1:0][1:0]   i_mode,
  input  wire logic [NCH-1:0][1:0]   i_src_sel,
  input  wire logic [NCH-1:0][1:0]   i_edge_sel,
  input  wire logic [NCH-1:0]        i_evt_other,
  input  wire logic [NCH-1:0]        i_mode_wr,
  // per channel count-start flag
  input  wire logic [NCH-1:0]        i_start,
  // per channel timer register write
  input  wire logic [NCH-1:0]        i_wr_en,
  input  wire logic [NCH-1:0][15:0]  i_wr_data,
  // per channel external input pin
  input  wire logic [NCH-1:0]        i_channel_external_input,
  // per channel status
  output logic      [NCH-1:0][15:0]  o_rd_data,
  output logic      [NCH-1:0]        o_irq,
  output logic      [NCH-1:0]        o_ovf
);

  tbt_tick_if tick_bus ();

  // shared count-source prescaler
  tbt_prescaler u_presc (
    .i_clk    (i_clk),
    .i_arst_n (i_arst_n),
    .i_subclk (i_subclk),
    .tick     (tick_bus.src)
  );

  // underflow pulses of all channels, for cascaded event counting
  logic [NCH-1:0] unf;
  // the same pulses one cycle later, as seen by the neighbour
  logic [NCH-1:0] unf_q;

  genvar ch;
  generate
    for (ch = 0; ch < NCH; ch++) begin : g_ch
      logic [15:0]       counter;
      logic [15:0]       reload;
      logic              ext_meta;
      logic              ext_sync;
      logic              ext_last;
      logic              src_tick;
      logic              edge_hit;
      logic              evt_tick;
      logic              first_seen;
      logic              run;
      logic              at_zero;
      logic              at_top;
      tbt_pkg::tbt_mode_e mode;

      assign mode    = tbt_pkg::tbt_mode_e'(i_mode[ch]); // R1
      assign run     = i_start[ch]; // R6 R7
      assign at_zero = (counter == tbt_pkg::CNT_RST);
      assign at_top  = (counter == tbt_pkg::CNT_ALL_ONE);

      // internal count-source selection
      always_comb begin
        unique case (i_src_sel[ch]) // R3 R13
          tbt_pkg::SRC_DIV1:  src_tick = tick_bus.tick_div1;
          tbt_pkg::SRC_DIV8:  src_tick = tick_bus.tick_div8;
          tbt_pkg::SRC_DIV32: src_tick = tick_bus.tick_div32;
          tbt_pkg::SRC_SUB32: src_tick = tick_bus.tick_sub32;
        endcase
      end

      // two-flop sampling of the external pin, then edge memory
      always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
          ext_meta <= 1'b0;
          ext_sync <= 1'b0;
          ext_last <= 1'b0;
        end else begin
          ext_meta <= i_channel_external_input[ch];
          ext_sync <= ext_meta;
          ext_last <= ext_sync;
        end
      end

      // effective edge detection on the sampled pin
      always_comb begin
        case (i_edge_sel[ch])
          tbt_pkg::EDGE_FALL: edge_hit = ext_last && !ext_sync;
          tbt_pkg::EDGE_RISE: edge_hit = ext_sync && !ext_last;
          tbt_pkg::EDGE_BOTH: edge_hit = ext_sync != ext_last;
          default:            edge_hit = 1'b0; // reserved code
        endcase
      end

      // event source: pin edge or the neighbour channel's underflow;
      // registered, so two channels counting each other form no loop
      assign evt_tick = i_evt_other[ch] ? unf_q[(ch + 1) % NCH]
                                        : edge_hit; // R2

      // reload register: software writes in counting modes
      always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
          reload <= tbt_pkg::RELOAD_RST;
        end else if (mode == tbt_pkg::MODE_MEASURE) begin
          if (run && edge_hit) begin
            reload <= counter; // measurement result
          end
        end else if (i_wr_en[ch]) begin
          reload <= i_wr_data[ch]; // R10 R11 R12
        end
      end

      // counter
      always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
          counter <= tbt_pkg::CNT_RST;
        end else begin
          unique case (mode)
            tbt_pkg::MODE_TIMER, tbt_pkg::MODE_EVENT: begin
              if (!run) begin
                if (i_wr_en[ch]) begin
                  counter <= i_wr_data[ch]; // R10
                end
              end else if ((mode == tbt_pkg::MODE_TIMER) ? src_tick
                                                         : evt_tick) begin
                if (at_zero) begin
                  // a write in the same cycle is already the new reload
                  counter <= i_wr_en[ch] ? i_wr_data[ch] : reload; // R4 R11
                end else begin
                  counter <= counter - 16'h0001; // R4 R5
                end
              end
            end
            tbt_pkg::MODE_MEASURE: begin
              if (run) begin
                if (edge_hit) begin
                  counter <= tbt_pkg::CNT_RST;
                end else if (src_tick) begin
                  counter <= counter + 16'h0001; // wraps at overflow
                end
              end
            end
            tbt_pkg::MODE_UNUSED: begin
              counter <= counter; // held
            end
          endcase
        end
      end

      // first measurement edge after start raises no request
      always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
          first_seen <= 1'b0;
        end else if (!run || mode != tbt_pkg::MODE_MEASURE) begin
          first_seen <= 1'b0;
        end else if (edge_hit) begin
          first_seen <= 1'b1;
        end
      end

      // underflow pulse, used by the neighbour and for the request
      assign unf[ch] = run && at_zero &&
                       ((mode == tbt_pkg::MODE_TIMER && src_tick) ||
                        (mode == tbt_pkg::MODE_EVENT && evt_tick));

      // registered underflow for the neighbour's event counting
      always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
          unf_q[ch] <= 1'b0;
        end else begin
          unf_q[ch] <= unf[ch];
        end
      end

      // interrupt request pulse
      always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
          o_irq[ch] <= 1'b0;
        end else if (mode == tbt_pkg::MODE_MEASURE) begin
          o_irq[ch] <= run && ((edge_hit && first_seen) ||
                               (src_tick && !edge_hit && at_top));
        end else begin
          o_irq[ch] <= unf[ch]; // R8
        end
      end

      // overflow flag: set wins over the clear by mode write
      always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
          o_ovf[ch] <= 1'b0;
        end else if (mode == tbt_pkg::MODE_MEASURE && run &&
                     src_tick && !edge_hit && at_top) begin
          o_ovf[ch] <= 1'b1;
        end else if (run && i_mode_wr[ch]) begin
          o_ovf[ch] <= 1'b0;
        end
      end

      // timer register read value, live count or measurement result
      always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
          o_rd_data[ch] <= tbt_pkg::CNT_RST;
        end else if (mode == tbt_pkg::MODE_MEASURE) begin
          o_rd_data[ch] <= reload;
        end else begin
          o_rd_data[ch] <= counter; // R9
        end
      end
    end
  endgenerate

endmodule : tbt_timer

// ---- bench/tbt_timer_chk.sv ----
/*
  checker for the interval timer: write, hold, count and irq timing.
  assumes the bench keeps channel 0 in timer mode throughout.
*/
`timescale 1ns/10ps
module tbt_timer_chk #(
  parameter int NCH = 2
) (
  // watched ports
  input wire logic                  i_clk,
  input wire logic                  i_arst_n,
  input wire logic [NCH-1:0][1:0]   i_mode,
  input wire logic [NCH-1:0][1:0]   i_src_sel,
  input wire logic [NCH-1:0]        i_start,
  input wire logic [NCH-1:0]        i_wr_en,
  input wire logic [NCH-1:0][15:0]  i_wr_data,
  input wire logic [NCH-1:0][15:0]  o_rd_data,
  input wire logic [NCH-1:0]        o_irq
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  logic t0, run, slow;

  // channel 0 conditions: timer mode, running undivided or by 8
  assign t0 = i_mode[0] == 2'h0;
  assign run = t0 && i_start[0] && i_src_sel[0] == 2'h0;
  assign slow = t0 && i_start[0] && i_src_sel[0] == 2'h1 && !i_wr_en[0];

  sequence stop_s;
    t0 && !i_start[0] && !i_wr_en[0];
  endsequence
  sequence run_s;
    run [*2];
  endsequence

  stop_write_a: assert property (
    t0 && !i_start[0] && i_wr_en[0] |=> ##1
    o_rd_data[0] == $past(i_wr_data[0], 2)) else $error("stopped write lost");
  ch1_write_a: assert property (
    i_mode[1] < 2'h2 && !i_start[1] && i_wr_en[1] |=> ##1
    o_rd_data[1] == $past(i_wr_data[1], 2)) else $error("ch1 write lost");
  stop_hold_a: assert property (
    stop_s |=> ##1 $stable(o_rd_data[0])) else $error("stopped count moved");
  run_count_a: assert property (
    run_s |=> $past(o_rd_data[0]) == 16'h0 ||
    o_rd_data[0] == $past(o_rd_data[0]) - 16'h1) else $error("bad count");
  irq_cause_a: assert property (
    o_irq[0] && t0 |-> o_rd_data[0] == 16'h0)
    else $error("irq without underflow");
  irq_pulse_a: assert property (
    o_irq[0] && t0 && i_src_sel[0] != 2'h0 |=> !o_irq[0])
    else $error("irq too long");
  stop_quiet_a: assert property (
    (t0 && !i_start[0]) [*2] |=> !o_irq[0]) else $error("irq while stopped");
  div8_gap_a: assert property (
    $past(slow, 2) && $changed(o_rd_data[0]) |=>
    ($stable(o_rd_data[0]) || !$past(slow, 2)) [*7])
    else $error("divide by 8 too fast");
endmodule : tbt_timer_chk

bind tbt_timer tbt_timer_chk #(.NCH(NCH)) u_chk (.i_clk, .i_arst_n,
  .i_mode, .i_src_sel, .i_start, .i_wr_en, .i_wr_data, .o_rd_data, .o_irq);

// ---- bench/tb.sv ----
/*
  bench for tbt_timer: periods per source, stopped and running writes,
  halt, event counting, cascade, measurement and overflow on channel 1.
  assumes the checker is bound to the design.
*/
`timescale 1ns/10ps
module tb;
  logic             i_clk, i_arst_n;
  logic             i_subclk = 1'b0;
  logic [1:0][1:0]  i_mode, i_src_sel, i_edge_sel;
  logic [1:0]       i_evt_other, i_mode_wr, i_start, i_wr_en, ext_in;
  logic [1:0][15:0] i_wr_data, o_rd_data;
  logic [1:0]       o_irq, o_ovf;
  int               n_errors, comparisons, c, c0;
  int               sc = 0;
  int               irqs[2] = '{0, 0};
  logic [15:0]      val;

  tbt_timer dut (
    .i_clk, .i_arst_n, .i_subclk, .i_mode, .i_src_sel, .i_edge_sel,
    .i_evt_other, .i_mode_wr, .i_start, .i_wr_en, .i_wr_data,
    .i_channel_external_input(ext_in), .o_rd_data, .o_irq, .o_ovf
  );

  // main clock
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  // sub-clock pin of ten cycles a period, and irq tally
  always @(posedge i_clk) begin
    sc <= (sc + 1) % 5;
    if (sc == 4) i_subclk <= ~i_subclk;
    for (int k = 0; k < 2; k++)
      if (o_irq[k] === 1'b1) irqs[k] <= irqs[k] + 1;
  end

  // model: cycles between underflows for a source and reload value
  function automatic int exp_per(int s, int n);
    return (n + 1) * (s == 0 ? 1 : s == 1 ? 8 : s == 2 ? 32 : 320);
  endfunction : exp_per

  task automatic print_verdict();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : print_verdict

  task automatic cmp(string what, logic [15:0] exp, logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp

  task automatic tick(int k);
    repeat (k) @(posedge i_clk);
  endtask : tick

  // one-cycle timer register write
  task automatic wr(int ch, logic [15:0] d);
    i_wr_en[ch] <= 1'b1;
    i_wr_data[ch] <= d;
    tick(1);
    i_wr_en[ch] <= 1'b0;
  endtask : wr

  // cycles until the next irq pulse, bounded
  task automatic wait_irq(int ch, output int cyc);
    cyc = 0;
    do begin
      tick(1);
      cyc++;
    end while (o_irq[ch] !== 1'b1 && cyc < 2000);
    if (cyc >= 2000) begin
      n_errors++;
      print_verdict();
    end
  endtask : wait_irq

  // main sequence
  initial begin
    {i_mode, i_src_sel, i_evt_other, i_mode_wr, i_start, i_wr_en} = '0;
    {i_wr_data, ext_in, n_errors, comparisons} = '0;
    i_edge_sel = 4'h5;
    i_arst_n = 1'b0;
    void'($urandom(32'hc72f));
    val = 16'($urandom_range(9, 3));
    tick(20);
    i_arst_n <= 1'b1;
    tick(2);
    cmp("rd0 reset", 16'h0, o_rd_data[0]);
    wr(0, val);
    wr(1, ~val);
    tick(2);
    cmp("rd0", val, o_rd_data[0]);
    cmp("rd1", ~val, o_rd_data[1]);
    for (int s = 3; s >= 0; s--) begin
      i_start[0] <= 1'b0;
      i_src_sel[0] <= 2'(s);
      wr(0, s == 0 ? val : 16'h1);
      i_start[0] <= 1'b1;
      wait_irq(0, c);
      wait_irq(0, c);
      cmp("period", 16'(exp_per(s, s == 0 ? val : 1)), 16'(c));
    end
    wr(0, val + 16'h3);
    wait_irq(0, c);
    cmp("old period", 16'(exp_per(0, val) - 1), 16'(c));
    wait_irq(0, c);
    cmp("new period", 16'(exp_per(0, val + 3)), 16'(c));
    i_start[0] <= 1'b0;
    tick(3);
    c = irqs[0];
    tick(40);
    cmp("irqs stopped", 16'(c), 16'(irqs[0]));
    i_mode[1] <= 2'h1;
    wr(1, 16'h1);
    i_start[1] <= 1'b1;
    c = irqs[1];
    repeat (4) begin
      ext_in[1] <= 1'b1;
      tick(4);
      ext_in[1] <= 1'b0;
      tick(4);
    end
    tick(6);
    cmp("events", 16'(4 / 2), 16'(irqs[1] - c));
    // cascade: channel 1 counts channel 0 underflows, reload 1 each
    i_evt_other[1] <= 1'b1;
    wr(0, 16'h1);
    i_start[0] <= 1'b1;
    c = irqs[1];
    c0 = irqs[0];
    tick(16);
    i_start[0] <= 1'b0;
    tick(3);
    cmp("underflows", 16'(16 / exp_per(0, 1)), 16'(irqs[0] - c0));
    cmp("cascade", 16'(8 / exp_per(0, 1)), 16'(irqs[1] - c));
    // measurement on channel 1: pin period of 12, first edge silent
    i_start[1] <= 1'b0;
    i_mode[1] <= 2'h2;
    tick(1);
    i_start[1] <= 1'b1;
    c = irqs[1];
    repeat (3) begin
      ext_in[1] <= 1'b1;
      tick(6);
      ext_in[1] <= 1'b0;
      tick(6);
    end
    tick(6);
    cmp("measured", 16'(12 - 1), o_rd_data[1]);
    // free run up to counter overflow, then clear by a mode write
    c0 = 0;
    while (o_ovf[1] !== 1'b1 && c0 < 70000) begin
      tick(1);
      c0++;
    end
    cmp("ovf set", 16'h1, 16'(o_ovf[1]));
    i_mode_wr[1] <= 1'b1;
    tick(1);
    i_mode_wr[1] <= 1'b0;
    tick(2);
    cmp("ovf clear", 16'h0, 16'(o_ovf[1]));
    cmp("measure irqs", 16'(3 - 1 + 1), 16'(irqs[1] - c));
    print_verdict();
  end
endmodule : tb
